// >>> core/rosq_pkg.sv
// Package: constants, types and decode functions of the reset and option byte sequencer
// Summary of operation
// [RL1] Main byte bit 0 picks watchdog start
// [RL2] Zero autostarts watchdog, one keeps it stopped
// [RL3] Bits 2 and 3 decide code protection
// [RL4] Bits 5:4 pick 3.80/2.85/2.35/1.90 V
// [RL5] One threshold serves both voltage resets
// [RL6] Bit 6 zero enables power-on/low-voltage resets
// [RL7] Bit 7 picks count source protect
// [RL8] Main byte at top address, blank FFh
// [RL9] Programmer erases before reprogramming a byte
// [RL10] Watchdog byte at fixed address, blank FFh
// [RL11] Bits 1:0 pick watchdog underflow count
// [RL12] Bits 3:2 pick refresh window fraction
// [RL13] Pin low holds everything in reset
// [RL14] Pin rising starts fetch from vector
// [RL15] Reset selects undivided slow oscillator clock
// [RL16] RAM untouched by reset
// [RL17] Stable supply: pin low 10 us
// [RL18] Power-up: pin low through settling plus 10 us
// [RL19] Release after 32 slow oscillator counts
// [RL20] Pulled-up pin: reset as supply rises
package rosq_pkg;

   localparam logic [15:0] RST_OPT_ADDR = 16'hFFFF;
   localparam logic [15:0] WDT_OPT_ADDR = 16'hFFDB;
   localparam logic [15:0] FLASH_CTL_ADDR = 16'hFF00;
   localparam logic [15:0] STATUS_ADDR = 16'hFF01;
   localparam logic [15:0] EFF_RST_ADDR = 16'hFF02;
   localparam logic [15:0] EFF_WDT_ADDR = 16'hFF03;
   localparam logic [15:0] CLK_CTL_ADDR = 16'hFF04;

   localparam logic [7:0] BLANK_BYTE = 8'hFF;
   localparam logic [7:0] ERASE_KEY = 8'hE5;

   localparam int WDT_START_BIT = 0;
   localparam int PROT_DIS_BIT = 2;
   localparam int PROT_EN_BIT = 3;
   localparam int LVL_LO_BIT = 4;
   localparam int LVL_HI_BIT = 5;
   localparam int LVD_START_BIT = 6;
   localparam int CSP_BIT = 7;
   localparam int UF_LO_BIT = 0;
   localparam int UF_HI_BIT = 1;
   localparam int WIN_LO_BIT = 2;
   localparam int WIN_HI_BIT = 3;

   localparam int ST_RUN_BIT = 0;
   localparam int ST_PIN_BIT = 1;
   localparam int ST_SUPPLY_BIT = 2;
   localparam int ST_SHORT_BIT = 3;
   localparam int ST_OVERWR_BIT = 4;
   localparam int ST_LVD_BIT = 5;

   localparam logic [5:0] LOSC_RELEASE_COUNT = 6'h20;
   localparam int CLK_PERIOD_NS = 100;
   localparam int PIN_LOW_MIN_NS = 10000;
   localparam int PIN_LOW_MIN_CYC = (PIN_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] PIN_LOW_MIN_CNT = PIN_LOW_MIN_CYC[7:0];

   typedef enum logic [3:0] {
      ST_POWERUP = 4'h1,
      ST_PIN_LOW = 4'h2,
      ST_LOAD = 4'h4,
      ST_RUN = 4'h8
   } rosq_state_t;

   typedef struct packed {
      logic wdt_autostart;
      logic cs_protect;
      logic code_protect;
      logic lvd_reset_en;
      logic [1:0] detect_sel;
      logic [1:0] uf_sel;
      logic [1:0] win_sel;
   } rosq_cfg_t;

   function automatic logic [13:0] rosq_uf_count(input logic [1:0] sel);
      logic [13:0] c;
      c = 14'h03FF;
      unique case (sel)
         2'h0: c = 14'h03FF;
         2'h1: c = 14'h0FFF;
         2'h2: c = 14'h1FFF;
         2'h3: c = 14'h3FFF;
      endcase
      return c;
   endfunction

   // Quarters of the full start-to-underflow span
   function automatic logic [14:0] rosq_win_count(input logic [1:0] uf, input logic [1:0] win);
      logic [14:0] quarter;
      logic [16:0] prod;
      quarter = ({1'b0, rosq_uf_count(uf)} + 15'h0001) >> 2;
      prod = quarter * ({15'h0000, win} + 17'h00001);
      return prod[14:0];
   endfunction

   function automatic logic [11:0] rosq_level_mv(input logic [1:0] sel);
      logic [11:0] mv;
      mv = 12'hED8;
      unique case (sel)
         2'h0: mv = 12'hED8;
         2'h1: mv = 12'hB22;
         2'h2: mv = 12'h92E;
         2'h3: mv = 12'h76C;
      endcase
      return mv;
   endfunction

endpackage

// >>> core/rosq_sync2.sv
// Two-stage synchroniser for pin-side levels
`timescale 1ns/1ns
module rosq_sync2 #(
   parameter int WIDTH = 3
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   // Meta stage feeds only the second stage
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end

   assign sync_o = sync_r;
endmodule

// >>> core/rosq_losc_counter.sv
// Slow oscillator tick counter for power-on release
`timescale 1ns/1ns
module rosq_losc_counter (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic clear_i,
   input wire logic tick_i,
   output logic done_o
);
   import rosq_pkg::*;

   logic [5:0] count_r;
   logic [5:0] count_nxt;
   wire reached = (count_r == LOSC_RELEASE_COUNT);

   assign count_nxt = clear_i ? 6'h00 : ((tick_i && !reached) ? count_r + 6'h01 : count_r); // RL19

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         count_r <= 6'h00;
      end else begin
         count_r <= count_nxt;
      end
   end

   assign done_o = reached;
endmodule

// >>> core/rosq_top.sv
// Reset sequencer top: option bytes, reset pin, power-on release
`timescale 1ns/1ns
module rosq_top (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic reset_pin_i,
   input wire logic supply_ok_i,
   input wire logic losc_clk_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output rosq_pkg::rosq_cfg_t cfg_o,
   output logic [13:0] wdt_underflow_count_o,
   output logic [14:0] wdt_refresh_window_o,
   output logic [11:0] detection0_threshold_mv_o,
   output logic sys_reset_n_o,
   output logic vector_fetch_o,
   output logic losc_clk_sel_o
);
   import rosq_pkg::*;

   // Pin-side levels, synchronised
   logic [2:0] sync_in;
   logic pin_high;
   logic supply_ok;
   logic losc_lvl;
   logic losc_prev_r;
   logic losc_tick;

   rosq_sync2 #(
      .WIDTH(3)
   ) u_sync (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .async_i({losc_clk_i, supply_ok_i, reset_pin_i}),
      .sync_o(sync_in)
   );

   assign pin_high = sync_in[0];
   assign supply_ok = sync_in[1];
   assign losc_lvl = sync_in[2];
   assign losc_tick = losc_lvl && !losc_prev_r;

   // Nonvolatile option bytes, blank after power-up model reset
   logic [7:0] rst_opt_r;
   logic [7:0] rst_opt_nxt;
   logic [7:0] wdt_opt_r;
   logic [7:0] wdt_opt_nxt;

   // Settings applied at the last reset release
   rosq_cfg_t eff_cfg_r;
   rosq_cfg_t stored_cfg;

   rosq_state_t state_r;
   rosq_state_t state_nxt;

   logic vector_fetch_r;
   logic sys_reset_n_r;
   logic clk_main_req_r;
   logic clk_main_req_nxt;
   logic losc_sel_r;
   logic short_flag_r;
   logic short_flag_nxt;
   logic overwr_flag_r;
   logic overwr_flag_nxt;
   logic [7:0] pin_low_cnt_r;
   logic [7:0] pin_low_cnt_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic losc_done;
   logic losc_clear;

   // Register decode
   wire wr_rst_opt = reg_wr_i && (reg_addr_i == RST_OPT_ADDR);
   wire wr_wdt_opt = reg_wr_i && (reg_addr_i == WDT_OPT_ADDR);
   wire wr_flash_ctl = reg_wr_i && (reg_addr_i == FLASH_CTL_ADDR);
   wire wr_status = reg_wr_i && (reg_addr_i == STATUS_ADDR);
   wire wr_clk_ctl = reg_wr_i && (reg_addr_i == CLK_CTL_ADDR);
   wire erase_req = wr_flash_ctl && (reg_wdata_i == ERASE_KEY);

   // Protection bit pairs and voltage start bit
   wire prot_disable = !rst_opt_r[PROT_DIS_BIT];
   wire prot_enable = !rst_opt_r[PROT_EN_BIT];
   wire lvd_en = !rst_opt_r[LVD_START_BIT];

   // Decode of the stored bytes into settings
   assign stored_cfg.wdt_autostart = !rst_opt_r[WDT_START_BIT]; // RL1 RL2
   assign stored_cfg.cs_protect = !rst_opt_r[CSP_BIT]; // RL7
   assign stored_cfg.code_protect = !prot_disable && prot_enable; // RL3
   assign stored_cfg.lvd_reset_en = lvd_en; // RL6
   assign stored_cfg.detect_sel = {rst_opt_r[LVL_HI_BIT], rst_opt_r[LVL_LO_BIT]}; // RL4
   assign stored_cfg.uf_sel = {wdt_opt_r[UF_HI_BIT], wdt_opt_r[UF_LO_BIT]}; // RL11
   assign stored_cfg.win_sel = {wdt_opt_r[WIN_HI_BIT], wdt_opt_r[WIN_LO_BIT]}; // RL12

   // Flash cells only clear bits when programmed; overwrite of a used byte is flagged
   assign rst_opt_nxt = erase_req ? BLANK_BYTE :
                        (wr_rst_opt ? (rst_opt_r & reg_wdata_i) : rst_opt_r); // RL8 RL9
   assign wdt_opt_nxt = erase_req ? BLANK_BYTE :
                        (wr_wdt_opt ? (wdt_opt_r & reg_wdata_i) : wdt_opt_r); // RL10 RL9

   wire overwr_event = (wr_rst_opt && (rst_opt_r != BLANK_BYTE)) ||
                       (wr_wdt_opt && (wdt_opt_r != BLANK_BYTE)); // RL9
   wire overwr_clear = erase_req || (wr_status && reg_wdata_i[ST_OVERWR_BIT]);

   // Set beats clear on a coincident event
   assign overwr_flag_nxt = overwr_event ? 1'b1 : (overwr_clear ? 1'b0 : overwr_flag_r);

   // Pin low time watch; a release before the minimum is flagged
   wire in_pin_low = (state_r == ST_PIN_LOW);
   wire short_event = in_pin_low && pin_high && (pin_low_cnt_r < PIN_LOW_MIN_CNT); // RL17
   wire short_clear = wr_status && reg_wdata_i[ST_SHORT_BIT];
   assign short_flag_nxt = short_event ? 1'b1 : (short_clear ? 1'b0 : short_flag_r);
   // Entry cycle counts as one, so a pulse of exactly the minimum is not short
   assign pin_low_cnt_nxt = !in_pin_low ? 8'h01 :
                            ((pin_low_cnt_r == 8'hFF) ? pin_low_cnt_r : pin_low_cnt_r + 8'h01);

   // Slow oscillator counting only while supply stays above the threshold
   assign losc_clear = (state_r != ST_POWERUP) || !supply_ok; // RL19

   rosq_losc_counter u_losc (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .clear_i(losc_clear),
      .tick_i(losc_tick),
      .done_o(losc_done)
   );

   // Reset sequencing
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_POWERUP: begin
            if (!pin_high) begin
               state_nxt = ST_PIN_LOW; // RL13
            end else if (lvd_en) begin
               if (losc_done) begin
                  state_nxt = ST_LOAD; // RL19
               end
            end else begin
               state_nxt = ST_LOAD; // RL20
            end
         end
         ST_PIN_LOW: begin
            if (pin_high) begin
               // Supply below threshold still blocks release when monitoring is on
               state_nxt = (lvd_en && !supply_ok) ? ST_POWERUP : ST_LOAD; // RL14 RL5
            end
         end
         ST_LOAD: begin
            if (!pin_high) begin
               state_nxt = ST_PIN_LOW; // RL13
            end else begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!pin_high) begin
               state_nxt = ST_PIN_LOW; // RL13
            end else if (lvd_en && !supply_ok) begin
               state_nxt = ST_POWERUP; // RL6 RL5
            end
         end
         default: begin
            state_nxt = ST_POWERUP;
         end
      endcase
   end

   wire enter_run = (state_r == ST_LOAD) && (state_nxt == ST_RUN);

   // Main clock request only honoured in run; dropped on the edge reset starts
   assign clk_main_req_nxt = ((state_r != ST_RUN) || (state_nxt != ST_RUN)) ? 1'b0 :
                             (wr_clk_ctl ? reg_wdata_i[0] : clk_main_req_r); // RL15

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         state_r <= ST_POWERUP;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         rst_opt_r <= BLANK_BYTE; // RL8
         wdt_opt_r <= BLANK_BYTE; // RL10
      end else begin
         rst_opt_r <= rst_opt_nxt;
         wdt_opt_r <= wdt_opt_nxt;
      end
   end

   // Settings latched only at release so cfg_o never sees a half-programmed byte; lvd_en and the detection 0 threshold track the stored byte
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         eff_cfg_r <= '0;
      end else if (state_r == ST_LOAD) begin
         eff_cfg_r <= stored_cfg; // RL1 RL7 RL11 RL12
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         sys_reset_n_r <= 1'b0;
         vector_fetch_r <= 1'b0;
         losc_sel_r <= 1'b1;
      end else begin
         sys_reset_n_r <= (state_nxt == ST_RUN); // RL13 RL20
         vector_fetch_r <= enter_run; // RL14
         losc_sel_r <= !clk_main_req_nxt; // RL15
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         clk_main_req_r <= 1'b0;
         short_flag_r <= 1'b0;
         overwr_flag_r <= 1'b0;
         pin_low_cnt_r <= 8'h01;
         losc_prev_r <= 1'b0;
      end else begin
         clk_main_req_r <= clk_main_req_nxt;
         short_flag_r <= short_flag_nxt;
         overwr_flag_r <= overwr_flag_nxt;
         pin_low_cnt_r <= pin_low_cnt_nxt;
         losc_prev_r <= losc_lvl;
      end
   end

   // Read path; unmapped addresses answer zero
   wire [7:0] status_word = {2'h0, lvd_en, overwr_flag_r, short_flag_r, supply_ok, pin_high,
                             (state_r == ST_RUN)};
   wire [7:0] eff_rst_word = {!eff_cfg_r.cs_protect, !eff_cfg_r.lvd_reset_en,
                              eff_cfg_r.detect_sel, 1'b0, eff_cfg_r.code_protect,
                              1'b1, !eff_cfg_r.wdt_autostart};
   wire [7:0] eff_wdt_word = {4'hF, eff_cfg_r.win_sel, eff_cfg_r.uf_sel};

   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            RST_OPT_ADDR: rdata_nxt = rst_opt_r;
            WDT_OPT_ADDR: rdata_nxt = wdt_opt_r;
            STATUS_ADDR: rdata_nxt = status_word;
            EFF_RST_ADDR: rdata_nxt = eff_rst_word;
            EFF_WDT_ADDR: rdata_nxt = eff_wdt_word;
            CLK_CTL_ADDR: rdata_nxt = {7'h00, clk_main_req_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Outputs; RAM has no reset path here, contents left to the RAM itself (RL16)
   assign reg_rdata_o = rdata_r;
   assign cfg_o = eff_cfg_r;
   assign wdt_underflow_count_o = rosq_uf_count(eff_cfg_r.uf_sel); // RL11
   assign wdt_refresh_window_o = rosq_win_count(eff_cfg_r.uf_sel, eff_cfg_r.win_sel); // RL12
   assign detection0_threshold_mv_o = rosq_level_mv(stored_cfg.detect_sel); // RL4 RL5
   assign sys_reset_n_o = sys_reset_n_r;
   assign vector_fetch_o = vector_fetch_r;
   assign losc_clk_sel_o = losc_sel_r;
endmodule

// >>> verif/rosq_props.sv
// Port-level checks of the reset sequencer
`timescale 1ns/1ns
module rosq_props (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic reset_pin_i,
   input wire logic supply_ok_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire rosq_pkg::rosq_cfg_t cfg_o,
   input wire logic [13:0] wdt_underflow_count_o,
   input wire logic [14:0] wdt_refresh_window_o,
   input wire logic [11:0] detection0_threshold_mv_o,
   input wire logic sys_reset_n_o,
   input wire logic vector_fetch_o,
   input wire logic losc_clk_sel_o
);
   import rosq_pkg::*;
   logic [7:0] m_r;
   logic [7:0] w_r;
   logic [13:0] uf_tab [4] = '{14'h03FF, 14'h0FFF, 14'h1FFF, 14'h3FFF};
   logic [14:0] q_tab [4] = '{15'h0100, 15'h0400, 15'h0800, 15'h1000};
   logic [11:0] mv_tab [4] = '{12'hED8, 12'hB22, 12'h92E, 12'h76C};
   wire erase = reg_wr_i && reg_addr_i == FLASH_CTL_ADDR && reg_wdata_i == ERASE_KEY;
   wire wr_m = reg_wr_i && reg_addr_i == RST_OPT_ADDR;
   wire wr_w = reg_wr_i && reg_addr_i == WDT_OPT_ADDR;
   wire rosq_cfg_t cfg_exp = {~m_r[0], ~m_r[7], m_r[2] & ~m_r[3], ~m_r[6], m_r[5:4], w_r[1:0], w_r[3:2]};
   // Flash-like shadow, programming can only clear bits
   always_ff @(posedge clock_i) begin
      if (!nrst_i || erase) begin
         m_r <= BLANK_BYTE;
         w_r <= BLANK_BYTE;
      end else begin
         m_r <= wr_m ? (m_r & reg_wdata_i) : m_r;
         w_r <= wr_w ? (w_r & reg_wdata_i) : w_r;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   sequence s_release;
      vector_fetch_o ##1 !vector_fetch_o;
   endsequence
   // Six samples cover the two-stage sync plus the output flop, which is fed from the next state
   sequence s_pin_low;
      (!reset_pin_i) [*6];
   endsequence
   property p_pin_hold;
      s_pin_low |-> !sys_reset_n_o;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("core runs with pin low");
   property p_vec;
      $rose(sys_reset_n_o) |-> s_release;
   endproperty
   a_vec: assert property (p_vec) else $error("no fetch pulse at release");
   property p_clk;
      !sys_reset_n_o || vector_fetch_o |-> losc_clk_sel_o;
   endproperty
   a_clk: assert property (p_clk) else $error("slow clock not selected");
   property p_uf;
      wdt_underflow_count_o == uf_tab[cfg_o.uf_sel];
   endproperty
   a_uf: assert property (p_uf) else $error("underflow count wrong");
   property p_win;
      wdt_refresh_window_o == 15'(q_tab[cfg_o.uf_sel] * (15'h0001 + cfg_o.win_sel));
   endproperty
   a_win: assert property (p_win) else $error("refresh window wrong");
   property p_thr;
      detection0_threshold_mv_o == mv_tab[m_r[5:4]];
   endproperty
   a_thr: assert property (p_thr) else $error("threshold wrong");
   property p_cfg;
      vector_fetch_o |-> cfg_o == cfg_exp;
   endproperty
   a_cfg: assert property (p_cfg) else $error("latched settings wrong");
   property p_rd_m;
      reg_rd_i && reg_addr_i == RST_OPT_ADDR |=> reg_rdata_o == $past(m_r);
   endproperty
   a_rd_m: assert property (p_rd_m) else $error("main byte read wrong");
   property p_rd_w;
      reg_rd_i && reg_addr_i == WDT_OPT_ADDR |=> reg_rdata_o == $past(w_r);
   endproperty
   a_rd_w: assert property (p_rd_w) else $error("watchdog byte read wrong");
   property p_lvd;
      (cfg_o.lvd_reset_en && !supply_ok_i) [*6] |-> !sys_reset_n_o;
   endproperty
   a_lvd: assert property (p_lvd) else $error("no reset on low supply");
endmodule

bind rosq_top rosq_props u_props (.*);

// >>> verif/rosq_reset_supervisor.sv
// External supervisor or pull-up driving the reset pin
`timescale 1ns/1ns
module rosq_reset_supervisor #(
   parameter int SETTLE_CYC = 20,
   parameter int LOW_CYC = 100
) (
   input wire logic clock_i,
   input wire logic supply_ok_i,
   input wire logic start_i,
   input wire logic rc_i,
   output logic pin_o
);
   // Settling time is board specific, plain default
   int cnt_r = SETTLE_CYC + LOW_CYC;
   always @(posedge clock_i) begin
      if (!supply_ok_i && !rc_i) begin
         cnt_r <= SETTLE_CYC + LOW_CYC;
      end else if (start_i) begin
         cnt_r <= LOW_CYC;
      end else if (cnt_r != 0) begin
         cnt_r <= cnt_r - 1;
      end
   end
   // Bare pull-up holds the pin high even with supply low, no supervisor timing
   assign pin_o = rc_i || (cnt_r == 0);
endmodule

// >>> verif/rosq_top_tb.sv
// Self-checking bench of the reset sequencer
`timescale 1ns/1ns
module rosq_top_tb;
   import rosq_pkg::*;
   typedef struct packed {
      logic [7:0] m;
      logic [7:0] w;
      logic [13:0] uf;
      logic [14:0] win;
      logic [11:0] mv;
   } rosq_row_t;
   // Every level, period and window code once
   rosq_row_t rows [4] = '{
      '{8'hCE, 8'hF0, 14'h03FF, 15'h0100, 12'hED8},
      '{8'h97, 8'hF5, 14'h0FFF, 15'h0800, 12'hB22},
      '{8'h6A, 8'hFA, 14'h1FFF, 15'h1800, 12'h92E},
      '{8'hFF, 8'hFF, 14'h3FFF, 15'h4000, 12'h76C}};
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic supply_ok_i = 1'b0;
   logic losc_clk_i = 1'b0;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic start = 1'b0;
   logic rc = 1'b0;
   logic reset_pin_i;
   logic [7:0] reg_rdata_o;
   rosq_cfg_t cfg_o;
   logic [13:0] wdt_underflow_count_o;
   logic [14:0] wdt_refresh_window_o;
   logic [11:0] detection0_threshold_mv_o;
   logic sys_reset_n_o;
   logic vector_fetch_o;
   logic losc_clk_sel_o;
   int n_mismatch = 0;
   int checked = 0;
   rosq_top uut (.*);
   rosq_reset_supervisor sup (.clock_i(clock_i), .supply_ok_i(supply_ok_i), .start_i(start), .rc_i(rc),
      .pin_o(reset_pin_i));
   initial forever #50 clock_i = ~clock_i;
   function automatic rosq_cfg_t exp_cfg(input logic [7:0] m, input logic [7:0] w);
      return {~m[0], ~m[7], m[2] & ~m[3], ~m[6], m[5:4], w[1:0], w[3:2]};
   endfunction
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checked=%0d mismatches=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1;
      cmp(16'(reg_rdata_o), 16'(e));
   endtask
   task automatic wait_rel(input int n);
      for (int i = 0; i < n && vector_fetch_o !== 1'b1; i++) begin
         @(posedge clock_i);
         #1;
      end
      if (vector_fetch_o !== 1'b1) begin
         n_mismatch++;
         $display("MISMATCH t=%0t release got=0 exp=1", $time);
         print_verdict();
      end
   endtask
   task automatic pin_reset();
      @(posedge clock_i);
      start <= 1'b1;
      @(posedge clock_i);
      start <= 1'b0;
      #1;
      wait_rel(200);
   endtask
   // Slow clock kept well below half the system rate
   task automatic losc(input int n);
      repeat (n) begin
         repeat (2) @(posedge clock_i);
         losc_clk_i <= 1'b1;
         repeat (2) @(posedge clock_i);
         losc_clk_i <= 1'b0;
      end
   endtask
   initial begin
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      supply_ok_i <= 1'b1;
      #1;
      cmp(16'(sys_reset_n_o), 16'h0000);
      cmp(16'(losc_clk_sel_o), 16'h0001);
      wait_rel(300);
      rd(RST_OPT_ADDR, BLANK_BYTE);
      rd(WDT_OPT_ADDR, BLANK_BYTE);
      rd(16'h0123, 8'h00);
      $display("test power-up done");
      foreach (rows[i]) begin
         wr(FLASH_CTL_ADDR, ERASE_KEY);
         wr(RST_OPT_ADDR, rows[i].m);
         wr(WDT_OPT_ADDR, rows[i].w);
         rd(RST_OPT_ADDR, rows[i].m);
         rd(WDT_OPT_ADDR, rows[i].w);
         cmp(16'(detection0_threshold_mv_o), 16'(rows[i].mv));
         pin_reset();
         cmp(16'(cfg_o), 16'(exp_cfg(rows[i].m, rows[i].w)));
         cmp(16'(wdt_underflow_count_o), 16'(rows[i].uf));
         cmp(16'(wdt_refresh_window_o), 16'(rows[i].win));
         $display("test row %0d done", i);
      end
      rd(STATUS_ADDR, 8'h07);
      rd(EFF_RST_ADDR, 8'hF3);
      rd(EFF_WDT_ADDR, 8'hFF);
      wr(RST_OPT_ADDR, 8'hFE);
      wr(RST_OPT_ADDR, 8'hFD);
      wr(FLASH_CTL_ADDR, 8'h00);
      rd(RST_OPT_ADDR, 8'hFC);
      rd(STATUS_ADDR, 8'h17);
      wr(STATUS_ADDR, 8'h10);
      rd(STATUS_ADDR, 8'h07);
      wr(FLASH_CTL_ADDR, ERASE_KEY);
      $display("test status done");
      wr(CLK_CTL_ADDR, 8'h01);
      rd(CLK_CTL_ADDR, 8'h01);
      cmp(16'(losc_clk_sel_o), 16'h0000);
      pin_reset();
      cmp(16'(losc_clk_sel_o), 16'h0001);
      rd(CLK_CTL_ADDR, 8'h00);
      $display("test clock select done");
      @(posedge clock_i);
      rc <= 1'b1;
      supply_ok_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      #1;
      cmp(16'(sys_reset_n_o), 16'h0001);
      @(posedge clock_i);
      supply_ok_i <= 1'b1;
      rc <= 1'b0;
      $display("test monitor off done");
      wr(FLASH_CTL_ADDR, ERASE_KEY);
      wr(RST_OPT_ADDR, 8'hBF);
      pin_reset();
      cmp(16'(cfg_o.lvd_reset_en), 16'h0001);
      @(posedge clock_i);
      rc <= 1'b1;
      supply_ok_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      #1;
      cmp(16'(sys_reset_n_o), 16'h0000);
      @(posedge clock_i);
      supply_ok_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      losc(31);
      repeat (6) @(posedge clock_i);
      #1;
      cmp(16'(sys_reset_n_o), 16'h0000);
      losc(1);
      wait_rel(20);
      cmp(16'(losc_clk_sel_o), 16'h0001);
      $display("test monitor release done");
      print_verdict();
   end
endmodule
